// file: core/operation_data_table.v
// Operation data table: eight sets, source selection and run checks
`timescale 1ns/1ps
`include "op_table_regs.vh"
module operation_data_table #(
    parameter SETS = 8
) (
    input  wire        I_CLK,
    input  wire        I_RST,
    // Host write port
    input  wire        i_wr,
    input  wire [2:0]  i_wr_set,
    input  wire [2:0]  i_wr_field,
    input  wire [15:0] i_wr_data,
    output reg         o_wr_ack,
    output reg         o_wr_reject,
    // Global parameters
    input  wire        i_ext_pwm_sel,
    input  wire [15:0] i_speed_lower,
    // Run control
    input  wire        i_start,
    input  wire        i_stop,
    input  wire [2:0]  i_run_set,
    output reg         o_running,
    output reg         o_prohibited,
    output wire        o_set_error,
    output wire [7:0]  o_set_error_map,
    // External inputs
    input  wire [15:0] i_analog_speed,
    input  wire [15:0] i_analog_torque,
    input  wire        i_pwm,
    // Command outputs
    output reg  [15:0] o_cmd_speed,
    output reg  [15:0] o_cmd_torque,
    output wire [15:0] o_cmd_accel,
    output wire [15:0] o_cmd_decel,
    output reg         o_ext_is_pwm,
    // Host read port
    input  wire [2:0]  i_rd_set,
    output wire [15:0] o_rd_speed,
    output wire [15:0] o_rd_torque,
    output wire [15:0] o_rd_accel,
    output wire [15:0] o_rd_decel,
    output wire [1:0]  o_rd_spd_src,
    output wire [1:0]  o_rd_trq_src
);
    // -----------------------------------------------------------------
    // Range checks
    // -----------------------------------------------------------------
    function in_range;
        input [2:0]  fld;
        input [15:0] d;
        begin
            case (fld)
                `FLD_SPEED:   in_range = (d == 16'h0000) ||
                                         (d >= `SPEED_MIN && d <= `SPEED_MAX); // R8
                `FLD_TORQUE:  in_range = (d <= `TORQUE_MAX);            // R9
                `FLD_ACCEL,
                `FLD_DECEL:   in_range = (d >= `TIME_MIN && d <= `TIME_MAX); // R10 R11
                `FLD_SPD_SRC,
                `FLD_TRQ_SRC: in_range = (d == {14'h0000, `SRC_DIGITAL}) ||
                                         (d == {14'h0000, `SRC_EXTERNAL}); // R2 R3
                default:      in_range = 1'b0;
            endcase
        end
    endfunction

    // Accepted write aimed at one field, shared by every storage element
    function field_hit;
        input       ok_wr;
        input [2:0] wfld;
        input [2:0] fld;
        begin
            field_hit = ok_wr && (wfld == fld);
        end
    endfunction

    wire ok = in_range(i_wr_field, i_wr_data);
    wire wr_ok = i_wr && ok; // R17

    // Write acknowledge and rejection report
    always @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            o_wr_ack    <= 1'b0;
            o_wr_reject <= 1'b0;
        end
        else
        begin
            o_wr_ack    <= wr_ok;
            o_wr_reject <= i_wr && !ok; // R17
        end
    end

    // -----------------------------------------------------------------
    // Numeric storage, one memory per field
    // -----------------------------------------------------------------
    reg  [2:0]  run_set;
    // Running set first, then the set about to start, else the host read set
    wire [2:0]  mem_raddr = o_running ? run_set : i_start ? i_run_set : i_rd_set;
    wire [15:0] m_speed;
    wire [15:0] m_torque;

    op_table_mem #(.WIDTH(16), .RST(`SPEED_RST)) u_speed ( // R1 R8
        .i_clk   (I_CLK),
        .i_rst   (I_RST),
        .i_we    (field_hit(wr_ok, i_wr_field, `FLD_SPEED)),
        .i_waddr (i_wr_set),
        .i_wdata (i_wr_data),
        .i_raddr (mem_raddr),
        .o_rdata (m_speed)
    );
    op_table_mem #(.WIDTH(16), .RST(`TORQUE_RST)) u_torque ( // R9
        .i_clk   (I_CLK),
        .i_rst   (I_RST),
        .i_we    (field_hit(wr_ok, i_wr_field, `FLD_TORQUE)),
        .i_waddr (i_wr_set),
        .i_wdata (i_wr_data),
        .i_raddr (mem_raddr),
        .o_rdata (m_torque)
    );
    op_table_mem #(.WIDTH(16), .RST(`TIME_RST)) u_accel ( // R10
        .i_clk   (I_CLK),
        .i_rst   (I_RST),
        .i_we    (field_hit(wr_ok, i_wr_field, `FLD_ACCEL)),
        .i_waddr (i_wr_set),
        .i_wdata (i_wr_data),
        .i_raddr (mem_raddr),
        .o_rdata (o_cmd_accel)
    );
    op_table_mem #(.WIDTH(16), .RST(`TIME_RST)) u_decel ( // R11
        .i_clk   (I_CLK),
        .i_rst   (I_RST),
        .i_we    (field_hit(wr_ok, i_wr_field, `FLD_DECEL)),
        .i_waddr (i_wr_set),
        .i_wdata (i_wr_data),
        .i_raddr (mem_raddr),
        .o_rdata (o_cmd_decel)
    );
    assign o_rd_speed  = m_speed;
    assign o_rd_torque = m_torque;
    assign o_rd_accel  = o_cmd_accel;
    assign o_rd_decel  = o_cmd_decel;

    // -----------------------------------------------------------------
    // Source selectors per set
    // -----------------------------------------------------------------
    // Each set owns its selector flops; the arrays gather them for host reads and command selection
    wire [1:0] spd_src     [0:SETS-1];
    wire [1:0] trq_src     [0:SETS-1];
    wire [1:0] trq_pending [0:SETS-1];
    genvar g;
    generate
        for (g = 0; g < SETS; g = g + 1)
        begin : g_src
            reg  [1:0] spd;
            reg  [1:0] trq;
            reg  [1:0] pend;
            wire       set_hit = (i_wr_set == g);
            wire       spd_wr  = set_hit && field_hit(wr_ok, i_wr_field, `FLD_SPD_SRC);
            wire       trq_wr  = set_hit && field_hit(wr_ok, i_wr_field, `FLD_TRQ_SRC);
            // Speed source applies at once; torque source waits for stop
            always @(posedge I_CLK or posedge I_RST)
            begin
                if (I_RST)
                begin
                    spd  <= `SRC_DIGITAL; // R4
                    trq  <= `SRC_DIGITAL; // R4
                    pend <= `SRC_DIGITAL;
                end
                else
                begin
                    if (spd_wr)
                        spd <= i_wr_data[1:0]; // R2
                    if (trq_wr)
                        pend <= i_wr_data[1:0]; // R3
                    // A write landing while idle goes straight through
                    if (!o_running)
                        trq <= trq_wr ? i_wr_data[1:0] : pend; // R12
                end
            end
            assign spd_src[g]     = spd;
            assign trq_src[g]     = trq;
            assign trq_pending[g] = pend;
            // Both external is a setting error
            assign o_set_error_map[g] = (spd == `SRC_EXTERNAL) &&
                                        (pend == `SRC_EXTERNAL); // R5
        end
    endgenerate
    assign o_set_error  = |o_set_error_map; // R5
    assign o_rd_spd_src = spd_src[i_rd_set];
    assign o_rd_trq_src = trq_pending[i_rd_set];

    // -----------------------------------------------------------------
    // Run control
    // -----------------------------------------------------------------
    // Refuse start on an errored set and flag prohibition
    always @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            o_running    <= 1'b0;
            o_prohibited <= 1'b0;
            run_set      <= 3'h0;
            o_ext_is_pwm <= 1'b0; // R7
        end
        else
        begin
            if (!o_running)
                o_ext_is_pwm <= i_ext_pwm_sel; // R7
            if (i_stop)
                o_running <= 1'b0;
            else if (i_start && !o_running)
            begin
                if (o_set_error_map[i_run_set])
                    o_prohibited <= 1'b1; // R6
                else
                begin
                    o_running    <= 1'b1;
                    o_prohibited <= 1'b0;
                    run_set      <= i_run_set;
                end
            end
        end
    end

    // -----------------------------------------------------------------
    // PWM duty measurement
    // -----------------------------------------------------------------
    reg        pwm_d;
    reg [15:0] per_cnt;
    reg [15:0] hi_cnt;
    reg [15:0] per_lat;
    reg [15:0] hi_lat;
    wire       pwm_rise = i_pwm && !pwm_d;
    // Count period and high time, latch on each rising edge
    always @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            pwm_d   <= 1'b0;
            per_cnt <= 16'h0000;
            hi_cnt  <= 16'h0000;
            per_lat <= 16'h0000;
            hi_lat  <= 16'h0000;
        end
        else
        begin
            pwm_d <= i_pwm;
            if (pwm_rise)
            begin
                per_lat <= per_cnt;
                hi_lat  <= hi_cnt;
                per_cnt <= 16'h0001;
                hi_cnt  <= 16'h0001;
            end
            else
            begin
                if (per_cnt != 16'hFFFF)
                    per_cnt <= per_cnt + 16'h0001;
                if (i_pwm && hi_cnt != 16'hFFFF)
                    hi_cnt <= hi_cnt + 16'h0001;
            end
        end
    end

    // Duty scaled to full range; a period outside limits reads as zero
    wire        per_ok = (per_lat >= `PWM_PER_MIN) && (per_lat <= `PWM_PER_MAX);
    wire [31:0] spd_num = hi_lat * `SPEED_MAX;
    wire [31:0] trq_num = hi_lat * `TORQUE_MAX;
    // High time never exceeds the period, so each quotient fits in 16 bits
    wire [31:0] spd_quo = spd_num / {16'h0000, per_lat};
    wire [31:0] trq_quo = trq_num / {16'h0000, per_lat};
    wire [15:0] pwm_speed  = per_ok ? spd_quo[15:0] : 16'h0000; // R16
    wire [15:0] pwm_torque = per_ok ? trq_quo[15:0] : 16'h0000;

    // -----------------------------------------------------------------
    // Command selection
    // -----------------------------------------------------------------
    reg [15:0] next_speed;
    reg [15:0] next_torque;
    // Pick digital or external per source, then apply lower limit to speed only
    always @*
    begin
        if (spd_src[run_set] == `SRC_DIGITAL)
            next_speed = m_speed; // R13
        else
            next_speed = o_ext_is_pwm ? pwm_speed : i_analog_speed; // R16
        if (next_speed != 16'h0000 && next_speed < i_speed_lower)
            next_speed = i_speed_lower; // R14
        if (trq_src[run_set] == `SRC_DIGITAL)
            next_torque = m_torque; // R13
        else
            next_torque = o_ext_is_pwm ? pwm_torque : i_analog_torque;
    end

    // Registered commands, zero speed when idle
    always @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            o_cmd_speed  <= 16'h0000;
            o_cmd_torque <= `TORQUE_RST;
        end
        else
        begin
            o_cmd_speed  <= o_running ? next_speed : 16'h0000;
            o_cmd_torque <= next_torque;
        end
    end
endmodule // operation_data_table

// file: core/op_table_regs.vh
// Constants for the operation data table
// Functional notes
// (R1) Eight data sets, each speed/torque/accel/decel
// (R2) Per-set speed source: 0 digital, 3 external
// (R3) Per-set torque source, same encoding
// (R4) Sources reset digital, changed per set
// (R5) Both sources external raises setting error
// (R6) Errored set selected: refuse start, prohibited
// (R7) Global external choice analog/PWM, reset analog
// (R8) Speed 0 or 80..3150, reset 0
// (R9) Torque 0..200 percent, reset 200
// (R10) Accel 0.1..15.0 s, reset 0.5 s
// (R11) Decel 0.1..15.0 s, reset 0.5 s
// (R12) Torque source change applied after stop
// (R13) Digital values used only with digital source
// (R14) Zero speed not raised by lower limit
// (R15) Host PWM frequency 1 to 25 kHz
// (R16) PWM source: speed from measured duty
// (R17) Out-of-range writes rejected, host told
`ifndef OP_TABLE_REGS_VH
`define OP_TABLE_REGS_VH
// -----------------------------------------------------------------
// Field selects
// -----------------------------------------------------------------
`define FLD_SPEED     3'h0
`define FLD_TORQUE    3'h1
`define FLD_ACCEL     3'h2
`define FLD_DECEL     3'h3
`define FLD_SPD_SRC   3'h4
`define FLD_TRQ_SRC   3'h5
// -----------------------------------------------------------------
// Source codes, limits and reset values
// -----------------------------------------------------------------
`define SRC_DIGITAL   2'h0
`define SRC_EXTERNAL  2'h3
`define SPEED_MIN     16'h0050
`define SPEED_MAX     16'h0C4E
`define SPEED_RST     16'h0000
`define SPEED_REF     16'h0BB8
`define TORQUE_MAX    16'h00C8
`define TORQUE_RST    16'h00C8
`define TIME_MIN      16'h0001
`define TIME_MAX      16'h0096
`define TIME_RST      16'h0005
// PWM period limits in clock cycles at 10 MHz: 25 kHz and 1 kHz
`define PWM_PER_MIN   16'h0190
`define PWM_PER_MAX   16'h2710
`endif

// file: core/op_table_mem.v
// Register-read memory holding one word per data set
`timescale 1ns/1ps
module op_table_mem #(
    parameter WIDTH = 16,
    parameter RST   = 16'h0000
) (
    input  wire             i_clk,
    input  wire             i_rst,
    input  wire             i_we,
    input  wire [2:0]       i_waddr,
    input  wire [WIDTH-1:0] i_wdata,
    input  wire [2:0]       i_raddr,
    output reg  [WIDTH-1:0] o_rdata
);
    reg [WIDTH-1:0] mem [0:7];
    integer k;

    // Storage with reset and registered read
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            for (k = 0; k < 8; k = k + 1)
                mem[k] <= RST;
            o_rdata <= RST;
        end
        else
        begin
            if (i_we)
                mem[i_waddr] <= i_wdata;
            o_rdata <= mem[i_raddr];
        end
    end
endmodule // op_table_mem

// file: sim/op_table_chk_assertions.sv
// Port checker for the operation data table
`timescale 1ns/1ps
module op_table_chk (
    input wire        I_CLK,
    input wire        I_RST,
    input wire        i_wr,
    input wire [2:0]  i_wr_field,
    input wire [15:0] i_wr_data,
    input wire        o_wr_ack,
    input wire        o_wr_reject,
    input wire        i_start,
    input wire        i_stop,
    input wire [2:0]  i_run_set,
    input wire        o_running,
    input wire        o_prohibited,
    input wire [7:0]  o_set_error_map,
    input wire        o_ext_is_pwm
);
    // ----
    // Writes
    // ----
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    a_bad_speed: assert property (i_wr && i_wr_field == 3'h0 && i_wr_data != 16'h0000
        && (i_wr_data < 16'h0050 || i_wr_data > 16'h0C4E) |=> o_wr_reject) else $error("speed");
    a_bad_torque: assert property (i_wr && i_wr_field == 3'h1 && i_wr_data > 16'h00C8
        |=> o_wr_reject && !o_wr_ack) else $error("torque");
    a_bad_time: assert property (i_wr && i_wr_field[2:1] == 2'h1
        && (i_wr_data == 16'h0000 || i_wr_data > 16'h0096) |=> o_wr_reject) else $error("time");
    a_bad_source: assert property (i_wr && i_wr_field[2:1] == 2'h2 && i_wr_data != 16'h0000
        && i_wr_data != 16'h0003 |=> o_wr_reject) else $error("source");
    a_one_answer: assert property (!(o_wr_ack && o_wr_reject)) else $error("both answers");
    // ----
    // Runs
    // ----
    sequence s_start;
        i_start && !i_stop && !o_running;
    endsequence
    a_prohibit_start: assert property (s_start ##0 o_set_error_map[i_run_set]
        |=> o_prohibited && !o_running) else $error("errored set ran");
    a_good_start: assert property (s_start ##0 !o_set_error_map[i_run_set]
        |=> o_running && !o_prohibited) else $error("good set refused");
    a_ext_hold: assert property (o_running && !i_stop
        |=> $stable(o_ext_is_pwm)) else $error("source moved in run");
endmodule // op_table_chk
bind operation_data_table op_table_chk u_chk (
    .I_CLK           (I_CLK),
    .I_RST           (I_RST),
    .i_wr            (i_wr),
    .i_wr_field      (i_wr_field),
    .i_wr_data       (i_wr_data),
    .o_wr_ack        (o_wr_ack),
    .o_wr_reject     (o_wr_reject),
    .i_start         (i_start),
    .i_stop          (i_stop),
    .i_run_set       (i_run_set),
    .o_running       (o_running),
    .o_prohibited    (o_prohibited),
    .o_set_error_map (o_set_error_map),
    .o_ext_is_pwm    (o_ext_is_pwm)
);

// file: sim/host_model.sv
// Host controller model: parameter writes and a PWM speed source
`timescale 1ns/1ps
module host_model (
    input  wire        i_clk,
    input  wire        i_ack,
    input  wire        i_reject,
    output reg         o_wr = 1'b0,
    output reg  [2:0]  o_set = 3'h0,
    output reg  [2:0]  o_field = 3'h0,
    output reg  [15:0] o_data = 16'h0000,
    output reg         o_pwm = 1'b0
);
    reg  [1:0]  resp;
    integer     ph = 0;
    // Write held to the taking edge; bus then shows junk, answer caught
    task write(input [2:0] s, input [2:0] f, input [15:0] d);
        @(posedge i_clk);
        #1;
        o_wr = 1'b1;
        o_set = s;
        o_field = f;
        o_data = d;
        @(posedge i_clk);
        #1;
        o_wr = 1'b0;
        o_data = ~d;
        resp = {i_ack, i_reject};
        if (resp == 2'h0)
        begin
            @(posedge i_clk);
            #1;
            resp = {i_ack, i_reject};
        end
    endtask
    // PWM at 10 kHz, 25 percent duty
    always @(posedge i_clk)
    begin
        ph <= (ph == 999) ? 0 : ph + 1;
        o_pwm <= ph < 250;
    end
endmodule // host_model

// file: sim/tb.sv
// Self-checking bench for the operation data table
`timescale 1ns/1ps
module tb;
    reg         I_CLK = 1'b0, I_RST = 1'b1, i_ext_pwm_sel = 1'b0, i_start = 1'b0, i_stop = 1'b0;
    reg  [2:0]  i_run_set = 3'h0, i_rd_set = 3'h0;
    reg  [15:0] i_speed_lower = 16'h01F4, i_analog_speed = 16'h0100, i_analog_torque = 16'h004D;
    wire        i_wr, i_pwm, o_wr_ack, o_wr_reject, o_running, o_prohibited, o_set_error;
    wire        o_ext_is_pwm;
    wire [1:0]  o_rd_spd_src, o_rd_trq_src;
    wire [2:0]  i_wr_set, i_wr_field;
    wire [7:0]  o_set_error_map;
    wire [15:0] i_wr_data, o_cmd_speed, o_cmd_torque, o_cmd_accel, o_cmd_decel;
    wire [15:0] o_rd_speed, o_rd_torque, o_rd_accel, o_rd_decel;
    integer     failures = 0, samples_checked = 0, i;
    operation_data_table dut (
        .I_CLK(I_CLK), .I_RST(I_RST), .i_wr(i_wr), .i_wr_set(i_wr_set),
        .i_wr_field(i_wr_field), .i_wr_data(i_wr_data), .o_wr_ack(o_wr_ack),
        .o_wr_reject(o_wr_reject), .i_ext_pwm_sel(i_ext_pwm_sel),
        .i_speed_lower(i_speed_lower), .i_start(i_start), .i_stop(i_stop),
        .i_run_set(i_run_set), .o_running(o_running), .o_prohibited(o_prohibited),
        .o_set_error(o_set_error), .o_set_error_map(o_set_error_map),
        .i_analog_speed(i_analog_speed), .i_analog_torque(i_analog_torque), .i_pwm(i_pwm),
        .o_cmd_speed(o_cmd_speed), .o_cmd_torque(o_cmd_torque), .o_cmd_accel(o_cmd_accel),
        .o_cmd_decel(o_cmd_decel), .o_ext_is_pwm(o_ext_is_pwm), .i_rd_set(i_rd_set),
        .o_rd_speed(o_rd_speed), .o_rd_torque(o_rd_torque), .o_rd_accel(o_rd_accel),
        .o_rd_decel(o_rd_decel), .o_rd_spd_src(o_rd_spd_src),
        .o_rd_trq_src(o_rd_trq_src));
    host_model host (.i_clk(I_CLK), .i_ack(o_wr_ack), .i_reject(o_wr_reject), .o_wr(i_wr),
        .o_set(i_wr_set), .o_field(i_wr_field), .o_data(i_wr_data), .o_pwm(i_pwm));
    // ----
    // Helpers
    // ----
    task chk(input [15:0] got, input [15:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task step;
        @(posedge I_CLK);
        #1;
    endtask
    task wr(input [2:0] s, input [2:0] f, input [15:0] d, input [1:0] e);
        host.write(s, f, d);
        chk({14'h0000, host.resp}, {14'h0000, e});
    endtask
    // Start or stop pulse, then one cycle for the command to settle
    task run(input st, input [2:0] s);
        step;
        i_run_set = s;
        i_start = st;
        i_stop = !st;
        step;
        i_start = 1'b0;
        i_stop = 1'b0;
        step;
    endtask
    task rd(input [2:0] s, input [15:0] sp, tq, ac, dc);
        step;
        i_rd_set = s;
        step;
        step;
        chk(o_rd_speed, sp);
        chk(o_rd_torque, tq);
        chk(o_rd_accel, ac);
        chk(o_rd_decel, dc);
        chk({12'h000, o_rd_spd_src, o_rd_trq_src}, 16'h0000);
    endtask
    task tally_and_finish;
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ----
    // Scenarios
    // ----
    task t_ranges;
        reg [20:0] tbl [0:12];
        tbl = '{{3'h0, 16'h0050, 2'h2}, {3'h0, 16'h0000, 2'h2}, {3'h0, 16'h0C4E, 2'h2},
            {3'h0, 16'h0C4F, 2'h1}, {3'h0, 16'h004F, 2'h1}, {3'h1, 16'h0000, 2'h2},
            {3'h1, 16'h00C9, 2'h1}, {3'h2, 16'h0096, 2'h2}, {3'h2, 16'h0097, 2'h1},
            {3'h2, 16'h0000, 2'h1}, {3'h3, 16'h0001, 2'h2}, {3'h4, 16'h0002, 2'h1},
            {3'h5, 16'h0001, 2'h1}};
        rd(3'h3, 16'h0000, 16'h00C8, 16'h0005, 16'h0005);
        for (i = 0; i < 13; i = i + 1)
            wr(3'h3, tbl[i][20:18], tbl[i][17:2], tbl[i][1:0]);
        rd(3'h3, 16'h0C4E, 16'h0000, 16'h0096, 16'h0001);
    endtask
    task t_error;
        wr(3'h2, 3'h4, 16'h0003, 2'h2);
        wr(3'h2, 3'h5, 16'h0003, 2'h2);
        chk({7'h00, o_set_error, o_set_error_map}, 16'h0104);
        run(1'b1, 3'h2);
        chk({14'h0000, o_prohibited, o_running}, 16'h0002);
    endtask
    task t_run;
        chk({15'h0000, o_ext_is_pwm}, 16'h0000);
        run(1'b1, 3'h0);
        chk(o_cmd_speed, 16'h0000);
        run(1'b0, 3'h0);
        wr(3'h1, 3'h0, 16'h03E8, 2'h2);
        run(1'b1, 3'h1);
        chk(o_cmd_speed, 16'h03E8);
        chk(o_cmd_accel, 16'h0005);
        chk(o_cmd_decel, 16'h0005);
        i_ext_pwm_sel = 1'b1;
        i_rd_set = 3'h1;
        wr(3'h1, 3'h5, 16'h0003, 2'h2);
        chk({14'h0000, o_rd_trq_src}, 16'h0003);
        repeat (3) step;
        chk({o_cmd_torque[14:0], o_ext_is_pwm}, 16'h0190);
        run(1'b0, 3'h1);
        run(1'b1, 3'h1);
        chk({14'h0000, o_cmd_torque != 16'h00C8, o_ext_is_pwm}, 16'h0003);
        run(1'b0, 3'h1);
        wr(3'h4, 3'h4, 16'h0003, 2'h2);
        run(1'b1, 3'h4);
        repeat (2500) step;
        chk({15'h0000, o_cmd_speed != 16'h0000}, 16'h0001);
        i_ext_pwm_sel = 1'b0;
        run(1'b0, 3'h4);
        run(1'b1, 3'h4);
        chk(o_cmd_speed, 16'h01F4);
        run(1'b0, 3'h1);
        run(1'b1, 3'h1);
        chk(o_cmd_torque, 16'h004D);
        run(1'b0, 3'h1);
    endtask
    // ----
    // Sequence
    // ----
    initial
        forever #50 I_CLK = ~I_CLK;
    initial
    begin
        #1000000;
        failures = failures + 1;
        tally_and_finish;
    end
    initial
    begin
        i_ext_pwm_sel = 1'b1;
        repeat (10) @(posedge I_CLK);
        #1;
        chk({13'h0000, o_ext_is_pwm, o_running, o_prohibited}, 16'h0000);
        I_RST = 1'b0;
        i_ext_pwm_sel = 1'b0;
        t_ranges;
        t_error;
        t_run;
        tally_and_finish;
    end
endmodule // tb
